// ---- verilog/sssic_pkg.sv ----
`default_nettype none
package sssic_pkg;
    //----------------------------------------
    // widths
    //----------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LOW_W = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = ADDR_W + LANES + DATA_W;

    //----------------------------------------
    // strap and reset values
    //----------------------------------------
    localparam logic MODE_INTERLEAVED = 1'h1;
    localparam logic MODE_RESET = MODE_INTERLEAVED;
    localparam logic [LOW_W-1:0] COUNT_RESET = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;

    //----------------------------------------
    // access state
    //----------------------------------------
    typedef enum logic [2:0] {
        SSSIC_DESEL = 3'h1,
        SSSIC_READ = 3'h2,
        SSSIC_WRITE = 3'h4
    } sssic_access_type;
endpackage : sssic_pkg
`default_nettype wire

// ---- verilog/sssic_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sssic_fifo_if #(parameter int WIDTH = sssic_pkg::FIFO_W);
    logic pushValid;
    logic pushReady;
    logic [WIDTH-1:0] pushData;
    logic popValid;
    logic popReady;
    logic [WIDTH-1:0] popData;

    modport fill (output pushValid, output pushData, input pushReady);
    modport drain (input popValid, input popData, output popReady);
    modport store (
        input pushValid, input pushData, output pushReady,
        output popValid, output popData, input popReady
    );
endinterface : sssic_fifo_if
`default_nettype wire

// ---- verilog/sssic_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sssic_fifo #(
    parameter int WIDTH = sssic_pkg::FIFO_W,
    parameter int DEPTH = sssic_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // both sides
    sssic_fifo_if.store port
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] slots [DEPTH];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [PTR_W:0] count_q;
    logic doPush;
    logic doPop;

    assign port.pushReady = (count_q != DEPTH[PTR_W:0]);
    assign port.popValid = (count_q != '0);
    assign port.popData = slots[rdPtr_q];
    assign doPush = port.pushValid && port.pushReady;
    assign doPop = port.popValid && port.popReady;

    //----------------------------------------
    // storage
    //----------------------------------------
    always_ff @(posedge core_clk) begin
        if (doPush) begin
            slots[wrPtr_q] <= port.pushData;
        end
    end

    //----------------------------------------
    // pointers and fill level
    //----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doPush) begin
                wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (PTR_W + 1)'(doPush) - (PTR_W + 1)'(doPop);
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    fifo_bound_a: assert property (count_q <= DEPTH[PTR_W:0])
        else $error("fifo level above depth");
endmodule : sssic_fifo
`default_nettype wire

// ---- verilog/sssic_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// - selected only when select a and b low and select high is high
// - drive enable low lets pins drive; high three-states them as inputs
// - outputs off during write data phase whatever drive enable says
// - first clock leaving deselect keeps outputs three-stated
// - outputs three-stated while deselected
// - qualifier high: edge ignored, nothing captured, no state change
// - qualifier high does not deselect; previous cycle and outputs extend
// - input data captured into data register on rising edge
// - read data is word at address sampled at the read edge, no extra stage
// - strap high picks interleaved order, low picks linear order
// - unconnected strap behaves as high, interleaved order; no pull-up, mode_q takes the pin level at the first clock after reset
// - read starts on qualified edge, selected, write enable high, load
// - write data taken at edge after command, filtered by byte lanes
// - advance ignores selects and write enable, keeps latched access type
// - counter works on two low address bits and wraps
module sssic_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // address and control
    input wire logic [15:0] address,
    input wire logic chip_select_low_a,
    input wire logic chip_select_high,
    input wire logic chip_select_low_b,
    input wire logic clock_qualifier_n,
    input wire logic writeEnable_n,
    input wire logic advance_or_load,
    input wire logic [3:0] byte_lane_write_n,
    input wire logic outputDrive_n,
    input wire logic burstModeStrap,
    // data pins
    input wire logic [31:0] dqIn,
    output logic [31:0] dqOut,
    output logic dqOe,
    // status
    output logic writeDropped
);
    //----------------------------------------
    // declarations
    //----------------------------------------
    logic [sssic_pkg::DATA_W-1:0] mem [2**sssic_pkg::ADDR_W];
    sssic_pkg::sssic_access_type access_q;
    logic [sssic_pkg::ADDR_W-1:0] base_q;
    logic [sssic_pkg::LOW_W-1:0] count_q;
    logic mode_q;
    logic modeCaught_q;
    logic driveSync_q;
    logic [sssic_pkg::DATA_W-1:0] rdData_q;
    logic [sssic_pkg::DATA_W-1:0] dataIn_q;
    logic wrPend_q;
    logic [sssic_pkg::ADDR_W-1:0] wrAddr_q;
    logic writeDropped_q;
    logic qual;
    logic selected;
    logic load;
    logic readHit;
    logic writeHit;
    logic [sssic_pkg::ADDR_W-1:0] effAddr;
    logic [sssic_pkg::LOW_W-1:0] nextCount;
    logic [sssic_pkg::LANES-1:0] popLanes;

    sssic_fifo_if #(.WIDTH(sssic_pkg::FIFO_W)) wq ();

    function automatic logic [1:0] burstLow(input logic mode, input logic [1:0] base,
                                            input logic [1:0] cnt);
        burstLow = mode ? (base ^ cnt) : 2'(base + cnt);
    endfunction : burstLow

    //----------------------------------------
    // edge decode
    //----------------------------------------
    // edge qualification
    assign qual = !clock_qualifier_n;
    assign selected = !chip_select_low_a && chip_select_high && !chip_select_low_b;
    assign load = !advance_or_load;
    assign nextCount = 2'(count_q + 2'h1);
    assign readHit = load ? (selected && writeEnable_n) : (access_q == sssic_pkg::SSSIC_READ);
    assign writeHit = load ? (selected && !writeEnable_n) : (access_q == sssic_pkg::SSSIC_WRITE);
    assign effAddr = load ? address
        : {base_q[15:2], burstLow(mode_q, base_q[1:0], nextCount)};

    //----------------------------------------
    // strap capture
    //----------------------------------------
    // order strap caught once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= sssic_pkg::MODE_RESET;
            modeCaught_q <= 1'h0;
        end else if (!modeCaught_q) begin
            mode_q <= burstModeStrap;
            modeCaught_q <= 1'h1;
        end
    end

    //----------------------------------------
    // access state and burst counter
    //----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_q <= sssic_pkg::SSSIC_DESEL;
            base_q <= sssic_pkg::ADDR_RESET;
            count_q <= sssic_pkg::COUNT_RESET;
        end else if (qual) begin
            if (load) begin
                base_q <= address;
                count_q <= sssic_pkg::COUNT_RESET;
                case (1'b1)
                    readHit: access_q <= sssic_pkg::SSSIC_READ;
                    writeHit: access_q <= sssic_pkg::SSSIC_WRITE;
                    default: access_q <= sssic_pkg::SSSIC_DESEL;
                endcase
            end else if (access_q != sssic_pkg::SSSIC_DESEL) begin
                count_q <= nextCount;
            end
        end
    end

    //----------------------------------------
    // output direction and read data
    //----------------------------------------
    // drive only after a read edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            driveSync_q <= 1'h0;
        end else if (qual) begin
            driveSync_q <= readHit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= sssic_pkg::DATA_RESET;
        end else if (qual && readHit) begin
            rdData_q <= mem[effAddr];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataIn_q <= sssic_pkg::DATA_RESET;
        end else if (qual && !dqOe) begin
            dataIn_q <= dqIn;
        end
    end

    //----------------------------------------
    // write path
    //----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_q <= 1'h0;
            wrAddr_q <= sssic_pkg::ADDR_RESET;
            writeDropped_q <= 1'h0;
        end else if (qual) begin
            wrPend_q <= writeHit;
            wrAddr_q <= effAddr;
            writeDropped_q <= wrPend_q && !wq.pushReady;
        end
    end

    assign wq.pushValid = qual && wrPend_q;
    assign wq.pushData = {wrAddr_q, byte_lane_write_n, dqIn};
    assign wq.popReady = qual && !readHit;
    assign popLanes = wq.popData[sssic_pkg::DATA_W +: sssic_pkg::LANES];

    sssic_fifo #(.WIDTH(sssic_pkg::FIFO_W), .DEPTH(sssic_pkg::FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .port(wq.store)
    );

    always_ff @(posedge core_clk) begin
        if (wq.popValid && wq.popReady) begin
            for (int b = 0; b < sssic_pkg::LANES; b++) begin
                if (!popLanes[b]) begin
                    mem[wq.popData[sssic_pkg::FIFO_W-1 -: sssic_pkg::ADDR_W]][8*b +: 8] <=
                        wq.popData[8*b +: 8];
                end
            end
        end
    end

    //----------------------------------------
    // pins
    //----------------------------------------
    assign dqOut = rdData_q;
    assign dqOe = driveSync_q && !outputDrive_n;
    assign writeDropped = writeDropped_q;

    //----------------------------------------
    // checks
    //----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence wrCmdSeq;
        qual && writeHit;
    endsequence

    sequence desSeq;
        qual && load && !selected;
    endsequence

    desel_off_a: assert property (desSeq |=> !dqOe [*1] ##0 !driveSync_q)
        else $error("driving after deselect edge");
    drive_gate_a: assert property (outputDrive_n |-> !dqOe)
        else $error("pins driven with drive enable high");
    write_phase_a: assert property (wrCmdSeq |=> !dqOe && wrPend_q)
        else $error("driving during write data phase");
    emerge_off_a: assert property (access_q == sssic_pkg::SSSIC_DESEL && !qual |=> !dqOe)
        else $error("driving while emerging from deselect");
    desel_hold_a: assert property (access_q == sssic_pkg::SSSIC_DESEL |-> !driveSync_q)
        else $error("driving while deselected");
    suspend_state_a: assert property (!qual |=> $stable(access_q) && $stable(base_q)
        && $stable(count_q) && $stable(dataIn_q))
        else $error("state changed on ignored edge");
    suspend_out_a: assert property (!qual ##1 !qual |=> $stable(driveSync_q)
        && $stable(rdData_q))
        else $error("output state changed during suspend");
    capture_in_a: assert property (qual && !dqOe |=> dataIn_q == $past(dqIn))
        else $error("input data not captured");
    read_data_a: assert property (qual && readHit |=> rdData_q == $past(mem[effAddr]))
        else $error("read data not from sampled address");
    mode_catch_a: assert property (!modeCaught_q |=> mode_q == $past(burstModeStrap))
        else $error("burst order strap not caught");
    read_start_a: assert property (qual && load && selected && writeEnable_n
        |=> access_q == sssic_pkg::SSSIC_READ && base_q == $past(address))
        else $error("read not started on load");
    write_push_a: assert property (qual && wrPend_q && wq.pushReady |-> wq.pushValid
        && wq.pushData[sssic_pkg::DATA_W-1:0] == dqIn)
        else $error("write data not taken at data edge");
    adv_keep_a: assert property (qual && !load |=> $stable(access_q)
        && base_q == $past(base_q))
        else $error("advance changed access type");
    count_step_a: assert property (qual && !load && access_q != sssic_pkg::SSSIC_DESEL
        |=> count_q == 2'($past(count_q) + 2'h1))
        else $error("burst counter did not step");
    order_addr_a: assert property (!load && !mode_q |-> effAddr[1:0]
        == 2'(base_q[1:0] + count_q + 2'h1))
        else $error("linear burst address wrong");
endmodule : sssic_top
`default_nettype wire

// ---- tb/sssic_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sssic_ctrl_model (
    // clock
    input wire logic core_clk,
    // address and control
    output logic [15:0] address,
    output logic chip_select_low_a,
    output logic chip_select_high,
    output logic chip_select_low_b,
    output logic clock_qualifier_n,
    output logic writeEnable_n,
    output logic advance_or_load,
    output logic [3:0] byte_lane_write_n,
    output logic outputDrive_n,
    output logic burstModeStrap,
    // data pins
    input wire logic [31:0] dqOut,
    input wire logic dqOe,
    output logic [31:0] dqIn
);
    logic [31:0] wrData = 32'h0;
    logic wrDrive = 1'h0;
    logic [31:0] lastLevel = 32'h0;
    //----------------------------------------
    // wire level
    //----------------------------------------
    // data only in data phase
    assign dqIn = dqOe ? dqOut : (wrDrive ? wrData : ~lastLevel);
    always @(posedge core_clk) lastLevel <= dqIn;
    initial begin
        address = 16'h0;
        {chip_select_low_a, chip_select_high, chip_select_low_b} = 3'h0;
        clock_qualifier_n = 1'h0;
        writeEnable_n = 1'h1;
        advance_or_load = 1'h0;
        byte_lane_write_n = 4'hF;
        outputDrive_n = 1'h0;
        burstModeStrap = 1'h1;
    end
    //----------------------------------------
    // requests
    //----------------------------------------
    // strap set only in reset
    task automatic set_strap(input logic m);
        burstModeStrap = m;
    endtask : set_strap
    task automatic cyc(input logic qN, input logic [2:0] sel, input logic weN,
        input logic adv, input logic [15:0] a, input logic drv, input logic [31:0] d,
        input logic [3:0] bw, input logic oeN);
        @(negedge core_clk);
        clock_qualifier_n = qN;
        {chip_select_low_a, chip_select_high, chip_select_low_b} = sel;
        writeEnable_n = weN;
        advance_or_load = adv;
        address = a;
        wrDrive = drv;
        wrData = d;
        byte_lane_write_n = bw;
        outputDrive_n = oeN;
        @(posedge core_clk);
        #2;
    endtask : cyc
endmodule : sssic_ctrl_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [15:0] address;
    logic csA, csHigh, csB, qualN, weN, adv, oeN, strap, dqOe, writeDropped;
    logic [3:0] bwN;
    logic [31:0] dqIn, dqOut;
    int miscompares = 0;
    int checks_done = 0;
    int cycleCount = 0;
    logic [31:0] mem [logic [15:0]];
    logic modeQ;
    logic [15:0] base;
    always #10 core_clk = ~core_clk;
    sssic_top sssic_top_inst (.core_clk(core_clk), .rst_n(rst_n), .address(address),
        .chip_select_low_a(csA), .chip_select_high(csHigh), .chip_select_low_b(csB),
        .clock_qualifier_n(qualN), .writeEnable_n(weN), .advance_or_load(adv),
        .byte_lane_write_n(bwN), .outputDrive_n(oeN), .burstModeStrap(strap),
        .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .writeDropped(writeDropped));
    sssic_ctrl_model sssic_ctrl_model_inst (.core_clk(core_clk), .address(address),
        .chip_select_low_a(csA), .chip_select_high(csHigh), .chip_select_low_b(csB),
        .clock_qualifier_n(qualN), .writeEnable_n(weN), .advance_or_load(adv),
        .byte_lane_write_n(bwN), .outputDrive_n(oeN), .burstModeStrap(strap),
        .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));
    //----------------------------------------
    // expectations and tasks
    //----------------------------------------
    function automatic logic [15:0] burst_addr(input logic [15:0] b, input int k,
        input logic m);
        logic [1:0] c;
        c = k[1:0];
        return {b[15:2], m ? (b[1:0] ^ c) : (b[1:0] + c)};
    endfunction : burst_addr
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic do_reset(input logic m);
        @(negedge core_clk);
        rst_n = 1'h0;
        sssic_ctrl_model_inst.set_strap(m);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'h1;
    endtask : do_reset
    task automatic idle(input int n);
        repeat (n) sssic_ctrl_model_inst.cyc(0, 3'h0, 1, 0, 16'h0, 0, 32'h0, 4'hF, 0);
    endtask : idle
    task automatic wr_burst(input logic [15:0] b, input int n, input logic [3:0] lanes);
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] m;
        sssic_ctrl_model_inst.cyc(0, 3'h2, 0, 0, b, 0, 32'h0, 4'hF, 0);
        for (int k = 0; k < n; k++) begin
            a = burst_addr(b, k, modeQ);
            d = $urandom;
            m = mem.exists(a) ? mem[a] : 32'h0;
            for (int i = 0; i < 4; i++) if (!lanes[i]) m[8*i+:8] = d[8*i+:8];
            mem[a] = m;
            `CHK(dqOe, 1'h0)
            sssic_ctrl_model_inst.cyc(0, (k == n-1) ? 3'h0 : 3'h2, 1, (k < n-1), 16'h0,
                1, d, lanes, 0);
        end
    endtask : wr_burst
    task automatic rd_burst(input logic [15:0] b, input int n);
        logic [31:0] keep;
        sssic_ctrl_model_inst.cyc(0, 3'h2, 1, 0, b, 0, 32'h0, 4'hF, 0);
        for (int k = 0; k < n; k++) begin
            `CHK(dqOut, mem[burst_addr(b, k, modeQ)])
            `CHK(dqOe, logic'(k != 2))
            if (k == 1) begin
                keep = dqOut;
                sssic_ctrl_model_inst.cyc(1, 3'h0, 0, 0, ~b, 1, 32'h0, 4'h0, 0);
                `CHK(dqOut, keep)
                `CHK(dqOe, 1'h1)
            end
            sssic_ctrl_model_inst.cyc(0, 3'h0, 0, (k < n-1), 16'h0, 0, 32'h0, 4'hF,
                (k == 1));
        end
        `CHK(dqOe, 1'h0)
    endtask : rd_burst
    //----------------------------------------
    // run
    //----------------------------------------
    always @(posedge core_clk) begin
        cycleCount++;
        if (cycleCount == 3000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(17));
        for (int p = 0; p < 2; p++) begin
            modeQ = ~p[0];
            do_reset(modeQ);
            `CHK(dqOe, 1'h0)
            `CHK(dqOut, 32'h0)
            `CHK(writeDropped, 1'h0)
            base = 16'($urandom);
            wr_burst(base, 4, 4'h0);
            for (int k = 0; k < 4; k++) wr_burst(burst_addr(base, k, 0), 1, 4'($urandom));
            idle(10);
            rd_burst({base[15:2], 2'($urandom)}, 4);
            rd_burst(base, 1);
            $display("test burst pass %0d done", p);
        end
        complete_run();
    end
endmodule : tb
`default_nettype wire
